// ---- hdl/bpci_pkg.sv ----
// bpci_pkg: register map, field positions, reset values and carriers of the
// eight-pin bidirectional port with change detection.
// assumes a 32-bit apb register bus and one 50 MHz clock.
package bpci_pkg;
  localparam int          BPCI_WIDTH       = 8;
  localparam int          BPCI_ADDR_W      = 8;
  // register byte offsets
  localparam logic [7:0]  OFS_PINS         = 8'h00; // second_port_pins
  localparam logic [7:0]  OFS_DIRECTION    = 8'h04; // second_port_direction
  localparam logic [7:0]  OFS_LATCH        = 8'h08; // second_port_output_latch
  localparam logic [7:0]  OFS_MAIN_IRQ     = 8'h0C; // main_irq_control
  localparam logic [7:0]  OFS_SECOND_IRQ   = 8'h10; // second_irq_control
  localparam logic [7:0]  OFS_ANALOG       = 8'h14; // analog input select
  // field positions
  localparam int          BIT_CHANGE_FLAG  = 0;     // pin_change_flag
  localparam int          BIT_PULLUP_N     = 7;     // pullup_enable_n
  localparam int          ANALOG_PINS      = 5;     // pins with analog input
  localparam int          CHG_LO           = 4;     // first change-detect pin
  localparam int          PIN_ENTRY        = 5;     // lowvolt_prog_entry pin
  localparam int          PIN_SCLK         = 6;     // prog_serial_clock pin
  localparam int          PIN_SDAT         = 7;     // prog_serial_data pin
  localparam int          PIN_PULSE5       = 4;     // pulse_out_five pin
  localparam int          PULSE_ALT        = 4;     // pulse_out_four index
  localparam int          PULSE_ON_4       = 5;     // pulse_out_five index
  // reset values
  localparam logic [7:0]  RST_DIRECTION    = 8'hFF; // all inputs
  localparam logic [7:0]  RST_LATCH        = 8'h00;
  localparam logic        RST_PULLUP_N     = 1'b1;  // pull-ups off
  localparam logic [4:0]  RST_ANALOG       = 5'h00;
  localparam logic [31:0] RD_ZERO          = 32'h00000000;

  // configuration fuses, static while running
  typedef struct packed {
    logic lowvolt_prog_enable;
    logic alt_pulse_pin_select;
    logic in_circuit_enable;
  } bpci_cfg_t;

  // pulse generator outputs and their enables
  typedef struct packed {
    logic [5:0] level;
    logic [5:0] enable;
  } bpci_pulse_t;

  // debug core drive of the serial data pin
  typedef struct packed {
    logic data;
    logic oe;
  } bpci_dbg_t;
endpackage

// ---- hdl/bpci_port.sv ----
// bpci_port: eight-pin general-purpose port with direction, output latch,
// shared weak pull-up, change detection on the upper four pins and an apb slave.
// assumes pins are synchronous-ish inputs resynchronised here; fuses static.
`timescale 1ns/1ps

// Function
// - port has eight pins, each usable as input or output
// - direction bit 1 makes the pin an input, driver off
// - direction bit 0 drives the pin from the output latch
// - output latch has its own address and reads back latch values
// - clearing bit 7 of second irq control enables all pull-ups
// - pull-up switched off on any pin set as output
// - pull-ups disabled after power-on reset
// - only upper four pins set as input take part in change detection
// - inputs compared with snapshot taken at last pin data access
// - mismatches ORed set change flag, bit 0 of main irq control
// - change flag can wake the device from sleep
// - mismatch keeps setting flag; access plus one cycle ends it
// - any pin data access updates snapshot, except memory-move writes
// - pin returning to snapshot level removes mismatch without access
// - pulse outputs on pins zero to four, pulse four alternately on pin five
// - routed pulse output four overrides the latch on pin five
// - analog select kills digital input on lower five pins, not output
// - low-voltage programming makes pin five only the entry input
// - pin six is serial clock, pin seven serial data for programming
// - programming or debug disables all other functions on pins six, seven
module bpci_port
  import bpci_pkg::*;
#(
  parameter int WIDTH = BPCI_WIDTH
) (
  input  wire  logic                   clk,
  input  wire  logic                   reset_n,
  input  wire  logic                   psel,
  input  wire  logic                   penable,
  input  wire  logic                   pwrite,
  input  wire  logic [BPCI_ADDR_W-1:0] paddr,
  input  wire  logic [31:0]            pwdata,
  input  wire  logic                   mem_move_write,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire  bpci_cfg_t              cfg,
  input  wire  bpci_pulse_t            pulse,
  input  wire  bpci_dbg_t              dbg,
  input  wire  logic [WIDTH-1:0]       pin_in,
  output logic [WIDTH-1:0]             pin_out,
  output logic [WIDTH-1:0]             pin_oe,
  output logic [WIDTH-1:0]             pin_pullup,
  output logic                         lowvolt_prog_entry,
  output logic                         prog_serial_clock,
  output logic                         prog_serial_data,
  output logic                         wake_request
);

  logic [WIDTH-1:0]       sync1_ff;
  logic [WIDTH-1:0]       sync2_ff;
  logic [WIDTH-1:0]       direction_ff;
  logic [WIDTH-1:0]       latch_ff;
  logic                   pullup_n_ff;
  logic [ANALOG_PINS-1:0] analog_ff;
  logic [WIDTH-1:CHG_LO]  snapshot_ff;
  logic                   mismatch_ff;
  logic                   flag_ff;
  logic                   pready_ff;
  logic [31:0]            prdata_ff;
  logic                   pslverr_ff;
  logic [WIDTH-1:0]       pin_out_ff;
  logic [WIDTH-1:0]       pin_oe_ff;
  logic [WIDTH-1:0]       pin_pullup_ff;
  logic                   entry_ff;
  logic                   psclk_ff;
  logic                   psdat_ff;
  logic                   wake_ff;

  logic                   access;
  logic                   wr_en;
  logic                   pins_hit;
  logic                   snap_upd;
  logic                   flag_clr;
  logic [WIDTH-1:0]       func_off;
  logic [WIDTH-1:0]       din;
  logic [WIDTH-1:0]       nxt_out;
  logic [WIDTH-1:0]       nxt_oe;
  logic [WIDTH-1:0]       nxt_pullup;
  logic                   nxt_mismatch;
  logic [31:0]            nxt_rdata;
  logic                   nxt_err;

  // zero-extend a byte-wide register into the data word
  function automatic logic [31:0] widen(input logic [WIDTH-1:0] v);
    widen = {{(32-WIDTH){1'b0}}, v};
  endfunction

  // true when the address names one of the mapped words
  function automatic logic mapped(input logic [BPCI_ADDR_W-1:0] a);
    mapped = (a == OFS_PINS) || (a == OFS_DIRECTION) || (a == OFS_LATCH) ||
             (a == OFS_MAIN_IRQ) || (a == OFS_SECOND_IRQ) || (a == OFS_ANALOG);
  endfunction

  // apb completion edge: one wait state, pready only after penable
  assign access   = psel & penable & pready_ff;
  assign wr_en    = access & pwrite & ~pslverr_ff;
  assign pins_hit = access & (paddr == OFS_PINS);
  // memory-move writes into the pin register leave the snapshot alone
  assign snap_upd = pins_hit & ~(pwrite & mem_move_write);
  assign flag_clr = wr_en & (paddr == OFS_MAIN_IRQ) & ~pwdata[BIT_CHANGE_FLAG];

  // pins whose port function is taken away by programming or debug
  always_comb begin
    func_off          = '0;
    func_off[PIN_ENTRY] = cfg.lowvolt_prog_enable;
    func_off[PIN_SCLK]  = cfg.in_circuit_enable;
    func_off[PIN_SDAT]  = cfg.in_circuit_enable;
  end

  // two-stage resynchroniser; only sync2 is used anywhere
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // digital input path: analog select or lost function reads as zero
  always_comb begin
    din = sync2_ff & ~func_off;
    din[ANALOG_PINS-1:0] = sync2_ff[ANALOG_PINS-1:0] & ~analog_ff;
  end

  // software-written registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      direction_ff <= RST_DIRECTION;
      latch_ff     <= RST_LATCH;
      pullup_n_ff  <= RST_PULLUP_N;
      analog_ff    <= RST_ANALOG;
    end else if (wr_en) begin
      case (paddr)
        OFS_DIRECTION:  direction_ff <= pwdata[WIDTH-1:0];
        // a write to the pin register lands in the latch as well
        OFS_PINS:       latch_ff     <= pwdata[WIDTH-1:0];
        OFS_LATCH:      latch_ff     <= pwdata[WIDTH-1:0];
        OFS_SECOND_IRQ: pullup_n_ff  <= pwdata[BIT_PULLUP_N];
        OFS_ANALOG:     analog_ff    <= pwdata[ANALOG_PINS-1:0];
        default:        latch_ff     <= latch_ff;
      endcase
    end
  end

  // snapshot for change detection taken at every counted pin access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      snapshot_ff <= '0;
    end else if (snap_upd) begin
      snapshot_ff <= din[WIDTH-1:CHG_LO];
    end
  end

  // mismatch is level-true, so a pin going back clears it by itself
  assign nxt_mismatch = |(direction_ff[WIDTH-1:CHG_LO] &
                          ~func_off[WIDTH-1:CHG_LO] &
                          (din[WIDTH-1:CHG_LO] ^ snapshot_ff));

  // registered mismatch gives the one cycle after an access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mismatch_ff <= 1'b0;
    end else begin
      mismatch_ff <= nxt_mismatch & ~snap_upd;
    end
  end

  // change flag: a pending mismatch beats a software clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= mismatch_ff | (flag_ff & ~flag_clr);
    end
  end

  // wake line follows the flag; sleep control lives outside
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= flag_ff;
    end
  end

  // pin drive: latch unless a pulse output or, on pin seven, the debug core owns the pin
  always_comb begin
    nxt_out = latch_ff;
    for (int i = 0; i < PULSE_ALT; i++) begin
      if (pulse.enable[i]) begin
        nxt_out[i] = pulse.level[i];
      end
    end
    if (pulse.enable[PULSE_ON_4]) begin
      nxt_out[PIN_PULSE5] = pulse.level[PULSE_ON_4];
    end
    if (cfg.alt_pulse_pin_select && pulse.enable[PULSE_ALT]) begin
      nxt_out[PIN_ENTRY] = pulse.level[PULSE_ALT];
    end
    nxt_oe = ~direction_ff;
    nxt_out[PIN_SDAT] = cfg.in_circuit_enable ? dbg.data : nxt_out[PIN_SDAT];
    nxt_oe[PIN_SDAT]  = cfg.in_circuit_enable ? dbg.oe : nxt_oe[PIN_SDAT];
    nxt_oe[PIN_ENTRY] = nxt_oe[PIN_ENTRY] & ~func_off[PIN_ENTRY];
    nxt_oe[PIN_SCLK]  = nxt_oe[PIN_SCLK] & ~func_off[PIN_SCLK];
    nxt_out = nxt_out & nxt_oe;
    // pull-ups only on live inputs
    nxt_pullup = {WIDTH{~pullup_n_ff}} & direction_ff & ~func_off;
  end

  // pin outputs straight from flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_ff    <= '0;
      pin_oe_ff     <= '0;
      pin_pullup_ff <= '0;
    end else begin
      pin_out_ff    <= nxt_out;
      pin_oe_ff     <= nxt_oe;
      pin_pullup_ff <= nxt_pullup;
    end
  end

  // programming pins: entry level, serial clock and data towards the debug core
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      entry_ff     <= 1'b0;
      psclk_ff     <= 1'b0;
      psdat_ff     <= 1'b0;
    end else begin
      entry_ff     <= cfg.lowvolt_prog_enable & sync2_ff[PIN_ENTRY];
      psclk_ff     <= cfg.in_circuit_enable & sync2_ff[PIN_SCLK];
      psdat_ff     <= cfg.in_circuit_enable & sync2_ff[PIN_SDAT];
    end
  end

  // read mux; pins register returns levels, latch returns latch
  always_comb begin
    nxt_err = ~mapped(paddr);
    case (paddr)
      OFS_PINS:       nxt_rdata = widen(din);
      OFS_DIRECTION:  nxt_rdata = widen(direction_ff);
      OFS_LATCH:      nxt_rdata = widen(latch_ff);
      OFS_MAIN_IRQ:   nxt_rdata = widen({{(WIDTH-1){1'b0}}, flag_ff});
      OFS_SECOND_IRQ: nxt_rdata = widen({pullup_n_ff, {(WIDTH-1){1'b0}}});
      OFS_ANALOG:     nxt_rdata = widen({{(WIDTH-ANALOG_PINS){1'b0}}, analog_ff});
      default:        nxt_rdata = RD_ZERO;
    endcase
  end

  // apb answer: one wait state, data and error held with pready
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= RD_ZERO;
      pslverr_ff <= 1'b0;
    end else if (psel && penable && !pready_ff) begin
      pready_ff  <= 1'b1;
      prdata_ff  <= pwrite ? RD_ZERO : nxt_rdata;
      pslverr_ff <= nxt_err;
    end else begin
      pready_ff  <= 1'b0;
      prdata_ff  <= RD_ZERO;
      pslverr_ff <= 1'b0;
    end
  end

  assign pready             = pready_ff;
  assign prdata             = prdata_ff;
  assign pslverr            = pslverr_ff;
  assign pin_out            = pin_out_ff;
  assign pin_oe             = pin_oe_ff;
  assign pin_pullup         = pin_pullup_ff;
  assign lowvolt_prog_entry = entry_ff;
  assign prog_serial_clock  = psclk_ff;
  assign prog_serial_data   = psdat_ff;
  assign wake_request       = wake_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_pin_access;
    snap_upd;
  endsequence

  // no new access and the upper pins hold still for one cycle
  sequence s_quiet_after;
    !snap_upd && $stable(din[WIDTH-1:CHG_LO]);
  endsequence

  sequence s_pins_at_snapshot;
    !snap_upd && (din[WIDTH-1:CHG_LO] == snapshot_ff);
  endsequence

  AST_INPUT_DRIVER_OFF:
    assert property ((direction_ff[0] && !func_off[0]) |=> !pin_oe[0])
    else $error("input pin still driven");

  AST_LATCH_DRIVES:
    assert property ((!direction_ff[WIDTH-1] && !cfg.in_circuit_enable)
                     |=> pin_oe[WIDTH-1] && pin_out[WIDTH-1] == $past(latch_ff[WIDTH-1]))
    else $error("output pin not driven from latch");

  AST_LATCH_READBACK:
    assert property ((psel && penable && !pready && !pwrite && paddr == OFS_LATCH)
                     |=> prdata == widen($past(latch_ff)))
    else $error("latch read does not return latch");

  AST_PULLUP_OFF_ON_OUTPUT:
    assert property (!$past(direction_ff[0]) |-> !pin_pullup[0])
    else $error("pull-up left on an output pin");

  AST_PULLUP_SHARED:
    assert property ((!pullup_n_ff && direction_ff[1]) |=> pin_pullup[1])
    else $error("pull-up not applied on input pin");

  AST_MISMATCH_SETS_FLAG:
    assert property (nxt_mismatch && !snap_upd |-> ##2 flag_ff)
    else $error("mismatch did not set change flag");

  AST_ACCESS_ENDS_MISMATCH:
    assert property (s_pin_access ##1 s_quiet_after |=> !mismatch_ff)
    else $error("mismatch survived a port access");

  AST_SET_BEATS_CLEAR:
    assert property ((flag_clr && mismatch_ff) |=> flag_ff)
    else $error("change flag lost to a clear");

  AST_OUTPUT_NO_COMPARE:
    assert property ((direction_ff[WIDTH-1:CHG_LO] == '0) |-> !nxt_mismatch)
    else $error("output pins caused a mismatch");

  AST_WAKE_FOLLOWS:
    assert property ($rose(flag_ff) |=> wake_request)
    else $error("wake request missing");

  AST_ALT_PULSE_PRIORITY:
    assert property ((cfg.alt_pulse_pin_select && pulse.enable[PULSE_ALT] &&
                      !direction_ff[PIN_ENTRY] && !cfg.lowvolt_prog_enable)
                     |=> pin_out[PIN_ENTRY] == $past(pulse.level[PULSE_ALT]))
    else $error("pulse four did not override latch");

  AST_ANALOG_READ_ZERO:
    assert property (analog_ff[0] |-> !din[0])
    else $error("analog pin read as digital");

  AST_PULLUP_ALL_OFF:
    assert property (pullup_n_ff |=> (pin_pullup == '0))
    else $error("pull-up on while shared control is set");

  AST_SNAPSHOT_ON_ACCESS:
    assert property (s_pin_access |=> snapshot_ff == $past(din[WIDTH-1:CHG_LO]))
    else $error("snapshot not taken at pin access");

  AST_MOVE_KEEPS_SNAPSHOT:
    assert property ((pins_hit && pwrite && mem_move_write) |=> $stable(snapshot_ff))
    else $error("memory-move write changed the snapshot");

  AST_RETURN_CLEARS:
    assert property (s_pins_at_snapshot |=> !mismatch_ff)
    else $error("mismatch kept after pins returned");

  // programming functions take the pins away from the port
  AST_ENTRY_PIN_ISOLATED:
    assert property (cfg.lowvolt_prog_enable |=> !pin_oe[PIN_ENTRY] && !pin_pullup[PIN_ENTRY])
    else $error("entry pin still used by the port");

  AST_PROG_PINS_ISOLATED:
    assert property (cfg.in_circuit_enable
                     |=> !pin_oe[PIN_SCLK] && !pin_pullup[PIN_SCLK] && !pin_pullup[PIN_SDAT])
    else $error("programming pins still used by the port");

endmodule

// ---- bench/bpci_pins_model.sv ----
// bpci_pins_model: the board around the port: external drivers, weak pull-ups
// and floating pins, resolved into the level each pin shows.
// assumes pin_out/pin_oe/pin_pullup from the port, ext_* from the bench.
`timescale 1ns/1ps
module bpci_pins_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_lvl
);
  logic [7:0] float_ff = 8'h55;

  // undriven pin wanders each cycle, so a stale value never passes for real
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end

  // device driver first, then external load, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if (pin_pullup[i]) begin
        pin_lvl[i] = 1'b1;
      end else begin
        pin_lvl[i] = float_ff[i];
      end
    end
  end
endmodule

// ---- bench/bpci_port_tb.sv ----
// bpci_port_tb: self-checking bench of the port, apb master and pin stimulus.
// assumes the pins model on the far side; fuses change only under reset.
`timescale 1ns/1ps
module bpci_port_tb;
  import bpci_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, mm;
  logic [7:0] paddr, pin_out, pin_oe, pin_pullup, ext_val, ext_en, pin_lvl;
  logic [31:0] pwdata, prdata, rd;
  logic prog_entry, psclk, psdat, wake, er;
  bpci_cfg_t cfg;
  bpci_pulse_t pulse;
  bpci_dbg_t dbg;
  int failures, num_checks, cyc;

  bpci_port bpci_port_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .mem_move_write(mm), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cfg(cfg), .pulse(pulse), .dbg(dbg), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .lowvolt_prog_entry(prog_entry),
    .prog_serial_clock(psclk), .prog_serial_data(psdat), .wake_request(wake));
  bpci_pins_model bpci_pins_model_inst (.clk(clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_val(ext_val),
    .ext_en(ext_en), .pin_lvl(pin_lvl));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; request held until pready is seen at an edge
  // no cycle count assumed; only the hang guard ends a wait
  task automatic apb(input int w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= (w != 0); paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic do_reset(input bpci_cfg_t c);
    reset_n <= 1'b0; cfg <= c;
    wt(8);
    reset_n <= 1'b1;
  endtask

  task automatic t_reset;
    apb(0, OFS_DIRECTION, 0); chk("dir", 32'hFF, rd);
    apb(0, OFS_LATCH, 0); chk("latch", 32'h00, rd);
    apb(0, OFS_SECOND_IRQ, 0); chk("pu_n", 1'b1, rd[7]);
    chk("pullup", 8'h00, pin_pullup);
    apb(0, 8'h40, 0); chk("err", 1'b1, er); // unmapped
    $display("test reset done");
  endtask

  task automatic t_dir_latch;
    ext_val <= 8'h0C;
    apb(1, OFS_LATCH, 32'hA5); apb(1, OFS_DIRECTION, 32'h0F); wt(4);
    chk("oe", 8'hF0, pin_oe); chk("out", 4'hA, pin_out[7:4]);
    apb(0, OFS_LATCH, 0); chk("latch", 32'hA5, rd);
    apb(0, OFS_PINS, 0); chk("pins", 32'hAC, rd);
    apb(1, OFS_ANALOG, 32'h1F); apb(0, OFS_PINS, 0); chk("ana", 32'hA0, rd);
    apb(1, OFS_DIRECTION, 0); wt(2); chk("anaout", 8'hA5, pin_out);
    apb(1, OFS_ANALOG, 0); apb(1, OFS_DIRECTION, 32'h0F);
    apb(1, OFS_SECOND_IRQ, 0); wt(2); chk("pu", 8'h0F, pin_pullup);
    apb(1, OFS_SECOND_IRQ, 32'h80); wt(2); chk("pu", 8'h00, pin_pullup);
    $display("test direction latch done");
  endtask

  task automatic flag_is(input string nm, input logic e);
    apb(1, OFS_MAIN_IRQ, 0); wt(1); apb(0, OFS_MAIN_IRQ, 0);
    chk(nm, e, rd[BIT_CHANGE_FLAG]);
  endtask

  task automatic t_change;
    apb(1, OFS_DIRECTION, 32'hFF); ext_val <= 8'h00; wt(4);
    apb(0, OFS_PINS, 0); wt(2); flag_is("idle", 0);
    // the port is left unread while the change is awaited
    ext_val <= 8'h20; wt(6);
    chk("wake", 1'b1, wake);
    flag_is("keep", 1);
    apb(0, OFS_PINS, 0); wt(1); flag_is("read", 0);
    ext_val <= 8'h60; wt(6); ext_val <= 8'h20; wt(6);
    flag_is("back", 0);
    ext_val <= 8'h30; wt(6);
    mm <= 1'b1; apb(1, OFS_PINS, 0); mm <= 1'b0; wt(1);
    flag_is("move", 1);
    apb(1, OFS_PINS, 0); wt(1); flag_is("write", 0);
    apb(1, OFS_LATCH, 32'hF0); apb(1, OFS_DIRECTION, 32'h0F);
    ext_val <= 8'h38; wt(6); flag_is("excl", 0);
    $display("test change done");
  endtask

  task automatic t_pulse;
    apb(1, OFS_LATCH, 0); apb(1, OFS_DIRECTION, 0);
    pulse <= '{level: 6'h20, enable: 6'h3F}; wt(3);
    chk("p5", 8'h10, pin_out);
    pulse.level <= 6'h10; wt(3); chk("p4", 8'h20, pin_out);
    pulse.level <= 6'h0F; wt(3); chk("p03", 8'h0F, pin_out);
    pulse <= '{level: 6'h00, enable: 6'h00};
    $display("test pulse done");
  endtask

  task automatic t_prog;
    do_reset(3'h5);
    ext_val <= 8'h60; dbg <= '{data: 1'b1, oe: 1'b1};
    apb(1, OFS_SECOND_IRQ, 0); wt(4);
    chk("pu", 8'h1F, pin_pullup);
    chk("entry", 1'b1, prog_entry);
    chk("pclk", 1'b1, psclk);
    chk("pdat_drive", 2'h3, {pin_oe[7], pin_out[7]});
    chk("pdat_in", 1'b1, psdat);
    apb(0, OFS_PINS, 0); chk("pins", 32'h00, rd);
    $display("test programming done");
  endtask

  initial begin
    failures = 0; num_checks = 0; cyc = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; mm = 0;
    pulse = '0; dbg = '0; ext_val = 8'h00; ext_en = 8'hFF;
    reset_n = 0; cfg = 3'h2;
    do_reset(3'h2);
    t_reset();
    t_dir_latch();
    t_change();
    t_pulse();
    t_prog();
    give_verdict();
  end
endmodule
